// File: hw/fskm_params.svh
// timing constants and rule notes for the fsk modem control block
`ifndef FSKM_PARAMS_SVH
`define FSKM_PARAMS_SVH
`define FSKM_CLK_MHZ          100
`define FSKM_TSEL_EXTERNAL    2'h3
// times in microseconds as measured
`define FSKM_CLEAR_ON_00_US   402000
`define FSKM_CLEAR_ON_01_US   30000
`define FSKM_CLEAR_ON_10_US   350000
`define FSKM_DET_ON_00_US     301000
`define FSKM_DET_ON_01_US     4000
`define FSKM_DET_ON_10_US     152000
`define FSKM_DET_OFF_00_US    21000
`define FSKM_DET_OFF_01_US    21000
`define FSKM_DET_OFF_10_US    4000
`define FSKM_HOLD_00_US       150000
`define FSKM_HOLD_01_US       150000
`define FSKM_HOLD_10_US       40000
`define FSKM_SOFT_OFF_US      10000
// release of clear-to-send, in nanoseconds
`define FSKM_CLEAR_OFF_NS     200
// derived cycle counts
`define FSKM_US2CYC(t)        ((t) * `FSKM_CLK_MHZ)
`define FSKM_CLEAR_OFF_CYC    ((`FSKM_CLEAR_OFF_NS * `FSKM_CLK_MHZ) / 1000)
`endif

// File: hw/fskm_pkg.sv
// types shared by the fsk modem control block
package fskm_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_CLEAR, TX_DROP} fskm_tx_state_t;
  typedef struct packed {
    logic carrier_on;
    logic mark_tone;
    logic fading;
  } fskm_tx_out_t;
endpackage : fskm_pkg

// File: hw/fskm_delay_timer.sv
// restartable delay counter: done while run has lasted target cycles
`timescale 1ns/100ps
module fskm_delay_timer #(
  parameter int W = 32
) (
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic         run,
  input  wire logic [W-1:0] target,
  output logic              done
);
  logic [W-1:0] cnt_r;

  // combinational done so the caller can act on the same edge; target of 0 acts as 1
  assign done = run && (cnt_r + {{(W-1){1'b0}}, 1'b1} >= target);

  // count restarts whenever run drops, holds once done
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      cnt_r <= '0;
    else if (!run)
      cnt_r <= '0;
    else if (!done)
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
  end
endmodule : fskm_delay_timer

// File: hw/fskm_ctrl.sv
// digital control timing of a single-chip fsk modem
`timescale 1ns/100ps
`include "fskm_params.svh"
module fskm_ctrl #(
  parameter logic [31:0] CLEAR_ON_00  = `FSKM_US2CYC(`FSKM_CLEAR_ON_00_US),
  parameter logic [31:0] CLEAR_ON_01  = `FSKM_US2CYC(`FSKM_CLEAR_ON_01_US),
  parameter logic [31:0] CLEAR_ON_10  = `FSKM_US2CYC(`FSKM_CLEAR_ON_10_US),
  parameter logic [31:0] DET_ON_00    = `FSKM_US2CYC(`FSKM_DET_ON_00_US),
  parameter logic [31:0] DET_ON_01    = `FSKM_US2CYC(`FSKM_DET_ON_01_US),
  parameter logic [31:0] DET_ON_10    = `FSKM_US2CYC(`FSKM_DET_ON_10_US),
  parameter logic [31:0] DET_OFF_00   = `FSKM_US2CYC(`FSKM_DET_OFF_00_US),
  parameter logic [31:0] DET_OFF_01   = `FSKM_US2CYC(`FSKM_DET_OFF_01_US),
  parameter logic [31:0] DET_OFF_10   = `FSKM_US2CYC(`FSKM_DET_OFF_10_US),
  parameter logic [31:0] HOLD_00      = `FSKM_US2CYC(`FSKM_HOLD_00_US),
  parameter logic [31:0] HOLD_01      = `FSKM_US2CYC(`FSKM_HOLD_01_US),
  parameter logic [31:0] HOLD_10      = `FSKM_US2CYC(`FSKM_HOLD_10_US),
  parameter logic [31:0] SOFT_OFF     = `FSKM_US2CYC(`FSKM_SOFT_OFF_US),
  parameter bit          MUTE_CAPABLE = 1'b1,
  parameter bit          RD_IDLE_LVL  = 1'b1
) (
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire logic                 transmit_request_n,
  input  wire logic                 transmit_bit,
  input  wire logic                 timer_select_low,
  input  wire logic                 timer_select_high,
  input  wire logic                 receive_mute_enable_n,
  input  wire logic                 external_timer_input_n,
  input  wire logic                 external_detect_n,
  input  wire logic                 external_mute_n,
  input  wire logic                 detector_on,
  input  wire logic                 demod_bit,
  output fskm_pkg::fskm_tx_out_t    tx_out,
  output logic                      clear_to_send_n,
  output logic                      carrier_detect_raw_n,
  output logic                      carrier_detect_qualified_n,
  output logic                      receive_data
);
  localparam logic [31:0] CLEAR_OFF = 32'(`FSKM_CLEAR_OFF_CYC);

  fskm_pkg::fskm_tx_state_t tx_state_r;
  fskm_pkg::fskm_tx_state_t tx_state_nxt;
  logic [1:0]   tsel;
  logic         ext_mode;
  logic         tx_req;
  logic         tx_req_d_r;
  logic         fade_r;
  logic         hold_r;
  logic         qual_on_r;
  logic         mute_active;
  logic         detect_eff;
  logic         tx_done;
  logic         det_done;
  logic         hold_done;
  logic         fade_done;
  logic [31:0]  tx_target;
  logic [31:0]  det_target;

  // pick a count from the timer code; code 11 never reaches the timers
  function automatic logic [31:0] sel_count(input logic [1:0] code, input logic [31:0] c00,
                                            input logic [31:0] c01, input logic [31:0] c10);
    case (code)
      2'h0:    sel_count = c00;
      2'h1:    sel_count = c01;
      default: sel_count = c10;
    endcase
  endfunction : sel_count

  assign tsel     = {timer_select_high, timer_select_low};
  assign ext_mode = (tsel == `FSKM_TSEL_EXTERNAL);
  assign tx_req   = ~transmit_request_n;

  // ---------------- transmit side ----------------
  // clear delay by code, release after a short fixed count
  assign tx_target = (tx_state_r == fskm_pkg::TX_DROP) ? CLEAR_OFF :
                     sel_count(tsel, CLEAR_ON_00, CLEAR_ON_01, CLEAR_ON_10);

  fskm_delay_timer #(.W(32)) u_tx_timer (
    .sys_clk (sys_clk),
    .reset   (reset),
    .run     ((tx_state_r == fskm_pkg::TX_WAIT) || (tx_state_r == fskm_pkg::TX_DROP)),
    .target  (tx_target),
    .done    (tx_done)
  );

  // drop passes through idle on re-request so the shared timer restarts cleanly
  always_comb
  begin
    tx_state_nxt = tx_state_r;
    case (tx_state_r)
      fskm_pkg::TX_IDLE:  if (tx_req && !ext_mode) tx_state_nxt = fskm_pkg::TX_WAIT;
      fskm_pkg::TX_WAIT:  if (!tx_req) tx_state_nxt = fskm_pkg::TX_IDLE;
                          else if (tx_done) tx_state_nxt = fskm_pkg::TX_CLEAR;
      fskm_pkg::TX_CLEAR: if (!tx_req) tx_state_nxt = fskm_pkg::TX_DROP;
      fskm_pkg::TX_DROP:  if (tx_req || tx_done) tx_state_nxt = fskm_pkg::TX_IDLE;
      default:            tx_state_nxt = fskm_pkg::TX_IDLE;
    endcase
    if (ext_mode)
      tx_state_nxt = fskm_pkg::TX_IDLE;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      tx_state_r <= fskm_pkg::TX_IDLE;
    else
      tx_state_r <= tx_state_nxt;
  end

  // external mode: clear-to-send is the outside timer's result, receive timed by the outside detect and hold
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      clear_to_send_n <= 1'b1;
    else if (ext_mode)
      clear_to_send_n <= external_timer_input_n | transmit_request_n;
    else
      clear_to_send_n <= !((tx_state_nxt == fskm_pkg::TX_CLEAR) ||
                           (tx_state_nxt == fskm_pkg::TX_DROP));
  end

  // soft turn-off: carrier keeps following the bit while amplitude decays
  fskm_delay_timer #(.W(32)) u_fade_timer (
    .sys_clk (sys_clk),
    .reset   (reset),
    .run     (fade_r && !tx_req),
    .target  (SOFT_OFF),
    .done    (fade_done)
  );

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      tx_req_d_r <= 1'b0;
      fade_r     <= 1'b0;
    end
    else
    begin
      tx_req_d_r <= tx_req;
      if (tx_req || fade_done)
        fade_r <= 1'b0;
      else if (tx_req_d_r)
        fade_r <= 1'b1;
    end
  end

  // tone sampled each cycle so mark/space tracks the bit at once
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      tx_out <= '0;
    else
    begin
      tx_out.carrier_on <= tx_req || (fade_r && !fade_done) || (tx_req_d_r && !tx_req);
      tx_out.mark_tone  <= transmit_bit;
      tx_out.fading     <= !tx_req && ((fade_r && !fade_done) || tx_req_d_r);
    end
  end

  // ---------------- receive side ----------------
  // mute hold armed while transmitting with mute enabled
  fskm_delay_timer #(.W(32)) u_hold_timer (
    .sys_clk (sys_clk),
    .reset   (reset),
    .run     (hold_r && !tx_req),
    .target  (sel_count(tsel, HOLD_00, HOLD_01, HOLD_10)),
    .done    (hold_done)
  );

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      hold_r <= 1'b0;
    else if (!MUTE_CAPABLE || receive_mute_enable_n || ext_mode)
      hold_r <= 1'b0;
    else if (tx_req)
      hold_r <= 1'b1;
    else if (hold_done)
      hold_r <= 1'b0;
  end

  // in external mode the outside hold timer tells us when to mute
  assign mute_active = MUTE_CAPABLE && !receive_mute_enable_n &&
                       (tx_req || (ext_mode ? !external_mute_n : hold_r));

  // raw detect is pure logic so only the analog path and the mute gating shape its timing
  assign detect_eff           = detector_on && !mute_active;
  assign carrier_detect_raw_n = !detect_eff;

  assign det_target = qual_on_r ? sel_count(tsel, DET_OFF_00, DET_OFF_01, DET_OFF_10)
                                : sel_count(tsel, DET_ON_00, DET_ON_01, DET_ON_10);

  // any bounce of raw detect drops run and restarts the delay
  fskm_delay_timer #(.W(32)) u_det_timer (
    .sys_clk (sys_clk),
    .reset   (reset),
    .run     (!ext_mode && (detect_eff != qual_on_r)),
    .target  (det_target),
    .done    (det_done)
  );

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      qual_on_r <= 1'b0;
    else if (ext_mode)
      qual_on_r <= !external_detect_n && !mute_active;
    else if (mute_active)
      qual_on_r <= 1'b0;
    else if (det_done)
      qual_on_r <= detect_eff;
  end

  assign carrier_detect_qualified_n = !qual_on_r;

  // mark hold has priority, then the idle level once demodulation stops
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      receive_data <= 1'b1;
    else if (mute_active || !qual_on_r)
      receive_data <= 1'b1;
    else if (!detector_on)
      receive_data <= RD_IDLE_LVL;
    else
      receive_data <= demod_bit;
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_carrier_on;
    tx_req |=> tx_out.carrier_on && (tx_out.mark_tone == $past(transmit_bit));
  endproperty
  a_carrier_on: assert property (p_carrier_on) else $error("carrier missing on request");

  property p_fade_keeps;
    $fell(tx_req) |=> tx_out.carrier_on && tx_out.fading;
  endproperty
  a_fade_keeps: assert property (p_fade_keeps) else $error("carrier cut at release");

  property p_raw_direct;
    carrier_detect_raw_n == !(detector_on && !mute_active);
  endproperty
  a_raw_direct: assert property (p_raw_direct) else $error("raw detect delayed");

  property p_qual_stable;
    // judged on the cycle that made the change, so changes made under mute or in external mode are exempt
    (!$past(ext_mode) && !$past(mute_active) && $changed(qual_on_r)) |-> $past(det_done);
  endproperty
  a_qual_stable: assert property (p_qual_stable) else $error("qualified detect not timed");

  property p_mark_hold;
    carrier_detect_qualified_n |=> receive_data;
  endproperty
  a_mark_hold: assert property (p_mark_hold) else $error("data not held at mark");

  property p_idle_level;
    (qual_on_r && !mute_active && !detector_on) |=> receive_data == RD_IDLE_LVL;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle level wrong");

  property p_mute;
    mute_active |=> carrier_detect_qualified_n && receive_data;
  endproperty
  a_mute: assert property (p_mute) else $error("mute not forcing high");

  property p_hold_after;
    (MUTE_CAPABLE && !receive_mute_enable_n && !ext_mode && $fell(tx_req)) |-> hold_r;
  endproperty
  a_hold_after: assert property (p_hold_after) else $error("mute hold not armed");

  property p_clear_release;
    (!ext_mode && tx_state_r == fskm_pkg::TX_CLEAR && !tx_req) |-> ##[1:25] clear_to_send_n;
  endproperty
  a_clear_release: assert property (p_clear_release) else $error("slow release");

  property p_ext_clear;
    (ext_mode && $past(ext_mode)) |-> clear_to_send_n ==
      ($past(external_timer_input_n) | $past(transmit_request_n));
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("external clear wrong");

  c_clear:   cover property (!ext_mode && $fell(clear_to_send_n));
  c_qual:    cover property (!ext_mode && $fell(carrier_detect_qualified_n));
  c_hold:    cover property (hold_r && !tx_req ##1 !hold_r);
  c_ext:     cover property (ext_mode && $fell(clear_to_send_n));
endmodule : fskm_ctrl

// File: verif/fskm_term_model.sv
// terminal-side model: drives request, bit and timer code, plays the outside timers
`timescale 1ns/100ps
module fskm_term_model #(
  parameter int EXT_CLR  = 12,
  parameter int EXT_DET  = 6,
  parameter int EXT_HOLD = 10
) (
  input  wire logic sys_clk,
  input  wire logic detector_on,
  output logic      transmit_request_n,
  output logic      transmit_bit,
  output logic      timer_select_low,
  output logic      timer_select_high,
  output logic      external_timer_input_n,
  output logic      external_detect_n,
  output logic      external_mute_n
);
  logic ext_mode;
  int   ext_cnt  = 0;
  int   det_cnt  = 0;
  int   hold_cnt = 0;
  // outside timers only run while the code hands timing to us
  assign ext_mode = timer_select_high && timer_select_low;
  // outside detect timer: qualifies after EXT_DET cycles of carrier, drops at once
  always @(posedge sys_clk)
    det_cnt <= (!detector_on || !ext_mode) ? 0 : det_cnt + 1;
  assign external_detect_n = !(ext_mode && detector_on && det_cnt >= EXT_DET);
  // outside mute hold: recharged while sending, runs down after release
  always @(posedge sys_clk)
    hold_cnt <= !ext_mode ? 0 : !transmit_request_n ? EXT_HOLD : (hold_cnt > 0) ? hold_cnt - 1 : 0;
  assign external_mute_n = !(ext_mode && hold_cnt > 0);
  // outside timer restarts whenever the request drops away
  always @(posedge sys_clk)
    ext_cnt <= (transmit_request_n || !ext_mode) ? 0 : ext_cnt + 1;
  // clears at once on release, as a discharged rc timer would
  assign external_timer_input_n = !(ext_mode && !transmit_request_n && ext_cnt >= EXT_CLR);
  initial
  begin
    transmit_request_n = 1'b1;
    transmit_bit       = 1'b1;
    timer_select_low   = 1'b0;
    timer_select_high  = 1'b0;
  end
  task automatic set_code(input logic [1:0] code);
    timer_select_high = code[1];
    timer_select_low  = code[0];
  endtask : set_code
  task automatic request(input logic on);
    transmit_request_n = !on;
  endtask : request
  task automatic put_bit(input logic b);
    transmit_bit = b;
  endtask : put_bit
endmodule : fskm_term_model

// File: verif/tb_fskm_ctrl.sv
// self-checking bench for the fsk modem control timing block
`timescale 1ns/100ps
module tb_fskm_ctrl;
  // shortened counts so that every timer code runs in a few hundred cycles
  localparam logic [2:0][31:0] CLR  = {32'h46, 32'h3C, 32'h32};
  localparam logic [2:0][31:0] DON  = {32'h14, 32'h5, 32'h1E};
  localparam logic [2:0][31:0] DOFF = {32'h4, 32'h8, 32'h8};
  localparam logic [2:0][31:0] HLD  = {32'hF, 32'h28, 32'h28};
  localparam int               SOFT = 32'h19;
  localparam int               EXT  = 32'hC;
  localparam int               EXT_DET  = 32'h6;
  localparam int               EXT_HOLD = 32'hA;
  logic                   sys_clk, reset, mute_n, ext_det_n, ext_mute_n;
  logic                   detector_on, demod_bit, req_n, tx_bit, ext_tmr_n;
  logic                   tsel_lo, tsel_hi;
  fskm_pkg::fskm_tx_out_t tx_out;
  logic                   cts_n, raw_n, qual_n, rd;
  int                     bad_count = 0;
  int                     checks_done = 0;

  fskm_ctrl #(
    .CLEAR_ON_00(CLR[0]), .CLEAR_ON_01(CLR[1]), .CLEAR_ON_10(CLR[2]),
    .DET_ON_00(DON[0]), .DET_ON_01(DON[1]), .DET_ON_10(DON[2]),
    .DET_OFF_00(DOFF[0]), .DET_OFF_01(DOFF[1]), .DET_OFF_10(DOFF[2]),
    .HOLD_00(HLD[0]), .HOLD_01(HLD[1]), .HOLD_10(HLD[2]), .SOFT_OFF(SOFT)
  ) dut (
    .sys_clk(sys_clk), .reset(reset), .transmit_request_n(req_n), .transmit_bit(tx_bit),
    .timer_select_low(tsel_lo), .timer_select_high(tsel_hi),
    .receive_mute_enable_n(mute_n), .external_timer_input_n(ext_tmr_n),
    .external_detect_n(ext_det_n), .external_mute_n(ext_mute_n),
    .detector_on(detector_on), .demod_bit(demod_bit), .tx_out(tx_out),
    .clear_to_send_n(cts_n), .carrier_detect_raw_n(raw_n),
    .carrier_detect_qualified_n(qual_n), .receive_data(rd)
  );
  fskm_term_model #(.EXT_CLR(EXT), .EXT_DET(EXT_DET), .EXT_HOLD(EXT_HOLD)) term (
    .sys_clk(sys_clk), .detector_on(detector_on), .transmit_request_n(req_n),
    .transmit_bit(tx_bit), .timer_select_low(tsel_lo), .timer_select_high(tsel_hi),
    .external_timer_input_n(ext_tmr_n), .external_detect_n(ext_det_n),
    .external_mute_n(ext_mute_n)
  );

  // 100 mhz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // timing figures carry a small window: registered paths add a cycle or two
  task automatic rng(input string nm, input int lo, input int hi, input int g);
    checks_done++;
    if (g < lo || g > hi)
    begin
      bad_count++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : rng
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick
  // cycles until a watched output reaches lvl; lim on a hang
  task automatic wait_for(input int w, input logic lvl, input int lim, output int n);
    n = 0;
    while (((w == 0) ? cts_n : (w == 1) ? qual_n : raw_n) !== lvl && n < lim)
    begin
      tick(1);
      n++;
    end
  endtask : wait_for
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic tx_case(input int c);
    int n;
    int tc;
    int tf;
    term.put_bit(1'b0);
    term.request(1'b1);
    tick(2);
    chk("carrier_on", 1, tx_out.carrier_on);
    chk("mark_tone", 0, tx_out.mark_tone);
    chk("early clear", 1, cts_n);
    wait_for(0, 1'b0, 500, n);
    rng("clear delay", CLR[c] - 2, CLR[c] + 1, n);
    term.put_bit(1'b1);
    tick(2);
    chk("mark_tone", 1, tx_out.mark_tone);
    term.request(1'b0);
    tc = 0;
    tf = 0;
    for (int i = 1; i <= 60; i++)
    begin
      tick(1);
      if (tc == 0 && cts_n === 1'b1) tc = i;
      if (tf == 0 && tx_out.carrier_on === 1'b0) tf = i;
      if (i == 2) chk("fading", 1, tx_out.fading);
      if (i == 3) term.put_bit(1'b0);
      if (i == 6) chk("fade tone", 0, tx_out.mark_tone);
    end
    rng("clear release", 18, 24, tc);
    rng("soft off", SOFT, SOFT + 3, tf);
  endtask : tx_case

  task automatic rx_case(input int c);
    int n;
    demod_bit = 1'b0;
    detector_on = 1'b1;
    #1;
    chk("raw on", 0, raw_n);
    tick(DON[c] / 2);
    detector_on = 1'b0;
    tick(2);
    detector_on = 1'b1;
    chk("bounce", 1, qual_n);
    chk("bounce data", 1, rd);
    wait_for(1, 1'b0, 500, n);
    rng("detect on", DON[c] - 1, DON[c] + 3, n);
    tick(2);
    chk("data low", 0, rd);
    demod_bit = 1'b1;
    tick(2);
    chk("data high", 1, rd);
    demod_bit = 1'b0;
    detector_on = 1'b0;
    #1;
    chk("raw off", 1, raw_n);
    tick(2);
    chk("idle level", 1, rd);
    chk("still qualified", 0, qual_n);
    wait_for(1, 1'b1, 500, n);
    rng("detect off", DOFF[c] - 3, DOFF[c] + 2, n);
    chk("mark hold", 1, rd);
  endtask : rx_case

  task automatic mute_case(input int c);
    int n;
    term.set_code(2'(c));
    mute_n = 1'b0;
    detector_on = 1'b1;
    wait_for(1, 1'b0, 500, n);
    term.request(1'b1);
    tick(2);
    chk("muted detect", 1, qual_n);
    chk("muted data", 1, rd);
    chk("muted raw", 1, raw_n);
    tick(5);
    term.request(1'b0);
    wait_for(2, 1'b0, 500, n);
    rng("mute hold", HLD[c] - 1, HLD[c] + 3, n);
    chk("hold detect", 1, qual_n);
    chk("hold data", 1, rd);
    detector_on = 1'b0;
    mute_n = 1'b1;
    tick(40);
  endtask : mute_case

  task automatic ext_case();
    int n;
    term.set_code(2'h3);
    detector_on = 1'b1;
    term.request(1'b1);
    tick(1);
    chk("ext detect early", 1, qual_n);
    chk("ext early clear", 1, cts_n);
    wait_for(1, 1'b0, 100, n);
    rng("ext detect", EXT_DET - 1, EXT_DET + 2, n);
    wait_for(0, 1'b0, 100, n);
    rng("ext clear", EXT - EXT_DET - 1, EXT - EXT_DET + 2, n);
    term.request(1'b0);
    tick(2);
    chk("ext release", 1, cts_n);
    chk("rx independent", 0, qual_n);
    mute_n = 1'b0;
    term.request(1'b1);
    tick(2);
    chk("ext muted", 1, qual_n);
    chk("ext muted raw", 1, raw_n);
    term.request(1'b0);
    wait_for(2, 1'b0, 100, n);
    rng("ext mute hold", EXT_HOLD - 1, EXT_HOLD + 2, n);
    chk("ext hold detect", 1, qual_n);
    tick(2);
    chk("ext detect back", 0, qual_n);
    mute_n = 1'b1;
    detector_on = 1'b0;
    tick(2);
    chk("ext detect off", 1, qual_n);
    chk("ext mark", 1, rd);
  endtask : ext_case

  // main sequence: every internal timer code, then mute, then external mode
  initial
  begin
    reset = 1'b1;
    mute_n = 1'b1;
    detector_on = 1'b0;
    demod_bit = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    for (int c = 0; c < 3; c++)
    begin
      term.set_code(2'(c));
      tx_case(c);
      rx_case(c);
    end
    mute_case(0);
    mute_case(2);
    ext_case();
    wrap_up();
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    #200000;
    bad_count++;
    wrap_up();
  end
endmodule : tb_fskm_ctrl
